// ### hdl/mprg_top.sv
// power state, reset and general-purpose pin control of the module
`timescale 1ns/1ps
// Overview of operation
// - general outputs driven low after reset
// - undriven general inputs read as one
// - power button rising edge leaves soft-off
// - low reset button holds hardware reset
// - carrier reset on any reset cause
// - high power-good means main power good
// - suspend warning precedes every sleep entry
// - ram-sleep indicator low in suspend-to-ram
// - shared disk/off indicator low in both
// - carrier may invert ram indicator for supply
// - pcie wake input wakes the system
// - low thermal input flags over-temperature
// - alert raises management interrupt or wakes
module mprg_top (
   input  wire logic       clock,           // 100 MHz standby clock
   input  wire logic       reset_n,         // async reset, active low
   input  wire logic       power_button_n,  // power button
   input  wire logic       reset_button_n,  // reset button
   input  wire logic       main_power_good, // main supply good
   input  wire logic       main_supply_low, // main supply under minimum
   input  wire logic       watchdog_expired,// watchdog timeout
   input  wire logic       soft_reset_req,  // software reset request
   input  wire logic       pcie_wake_n,     // pcie wake
   input  wire logic       battery_low_n,   // battery low event
   input  wire logic       over_temp_n,     // off-module temp alarm
   input  wire logic       mgmt_alert_n,    // management bus alert
   input  wire logic       alert_wake_en,   // alert wakes instead of smi
   input  wire logic [1:0] sleep_req,       // software sleep request
   input  wire logic       gen_out_we,      // software write strobe
   input  wire logic [3:0] gen_out_wdata,   // software output value
   input  wire logic [3:0] gen_in,          // general inputs
   input  wire logic [3:0] gen_in_driven,   // carrier drives gen_in
   output logic      [3:0] gen_out,         // general outputs
   output logic      [3:0] gen_in_value,    // sampled general inputs
   output logic            carrier_reset_n, // reset to carrier
   output logic            suspend_warn_n,  // imminent suspend
   output logic            sleep_ram_n,     // suspend-to-ram
   output logic            sleep_disk_n,    // disk sleep / soft off
   output logic            soft_off_n,      // same net as sleep_disk_n
   output logic            battery_event,   // battery low seen
   output logic            over_temp,       // over-temperature seen
   output logic            mgmt_irq         // management interrupt
);
   logic [1:0] rst_sync_reg;
   logic       rst_n;
   logic [8:0] raw_in;
   logic [8:0] syn;
   logic       btn_prev_reg;
   logic       btn_prev_next;
   logic       btn_rise;
   logic       wake_any;
   logic       hw_reset;
   mprg_pkg::mprg_state_type state_reg;
   mprg_pkg::mprg_state_type state_next;
   logic [1:0] target_reg;
   logic [1:0] target_next;
   logic [7:0] warn_cnt_reg;
   logic [7:0] warn_cnt_next;
   logic [3:0] gen_out_reg;
   logic [3:0] gen_out_next;
   logic [3:0] gen_in_reg;
   logic [3:0] gen_in_next;
   logic [5:0] out_reg;
   logic [5:0] out_next;

   // release of the async reset through two flip-flops
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // collect asynchronous inputs for the synchroniser bank
   assign raw_in = {~watchdog_expired, ~main_supply_low, mgmt_alert_n,
                    over_temp_n, battery_low_n, pcie_wake_n,
                    main_power_good, reset_button_n, power_button_n};

   mprg_sync #(
      .WIDTH (mprg_pkg::IN_COUNT),
      .INIT  (mprg_pkg::SYNC_RESET)
   ) mprg_sync_inst (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in (raw_in),
      .sync_out (syn)
   );

   // decode of reset causes and wake sources
   always_comb begin
      btn_prev_next = syn[mprg_pkg::IX_PWR_BTN];
      btn_rise      = syn[mprg_pkg::IX_PWR_BTN] & ~btn_prev_reg;
      hw_reset      = ~syn[mprg_pkg::IX_RST_BTN]
                    | ~syn[mprg_pkg::IX_PWR_GOOD]
                    | ~syn[mprg_pkg::IX_SUPPLY]
                    | ~syn[mprg_pkg::IX_WDOG]
                    | soft_reset_req;
      wake_any      = btn_rise | ~syn[mprg_pkg::IX_WAKE]
                    | (~syn[mprg_pkg::IX_ALERT] & alert_wake_en);
   end

   // power state machine
   always_comb begin
      state_next    = state_reg;
      target_next   = target_reg;
      warn_cnt_next = warn_cnt_reg;
      unique case (state_reg)
         mprg_pkg::MPRG_OFF: begin
            if (btn_rise) begin
               state_next = mprg_pkg::MPRG_ON;
            end
         end
         mprg_pkg::MPRG_ON: begin
            if (sleep_req != mprg_pkg::REQ_NONE) begin
               state_next    = mprg_pkg::MPRG_WARN;
               target_next   = sleep_req;
               warn_cnt_next = mprg_pkg::WARN_COUNT;
            end
         end
         mprg_pkg::MPRG_WARN: begin
            if (warn_cnt_reg > 8'h1) begin
               warn_cnt_next = warn_cnt_reg - 8'h1;
            end else if (target_reg == mprg_pkg::REQ_RAM) begin
               state_next = mprg_pkg::MPRG_RAM;
            end else if (target_reg == mprg_pkg::REQ_DISK) begin
               state_next = mprg_pkg::MPRG_DISK;
            end else begin
               state_next = mprg_pkg::MPRG_OFF;
            end
         end
         mprg_pkg::MPRG_RAM, mprg_pkg::MPRG_DISK: begin
            if (wake_any) begin
               state_next = mprg_pkg::MPRG_ON;
            end
         end
         default: state_next = mprg_pkg::MPRG_OFF;
      endcase
   end

   // general pins and status outputs
   always_comb begin
      gen_out_next = gen_out_reg;
      if (gen_out_we) begin
         gen_out_next = gen_out_wdata;
      end
      // any reset cause forces the outputs back low
      if (hw_reset) begin
         gen_out_next = mprg_pkg::GEN_OUT_RESET;
      end
      // undriven pins read as the pull-up level
      gen_in_next = (gen_in & gen_in_driven)
                  | (mprg_pkg::GEN_IN_IDLE & ~gen_in_driven);
      out_next[0] = ~(hw_reset | state_reg == mprg_pkg::MPRG_OFF);
      out_next[1] = ~(state_next == mprg_pkg::MPRG_WARN
                      || state_next == mprg_pkg::MPRG_RAM
                      || state_next == mprg_pkg::MPRG_DISK);
      out_next[2] = ~(state_next == mprg_pkg::MPRG_RAM);
      out_next[3] = ~(state_next == mprg_pkg::MPRG_DISK
                      || state_next == mprg_pkg::MPRG_OFF);
      out_next[4] = ~syn[mprg_pkg::IX_BATT];
      out_next[5] = ~syn[mprg_pkg::IX_TEMP];
   end

   // registers of the block
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= mprg_pkg::MPRG_OFF;
         target_reg   <= mprg_pkg::REQ_NONE;
         warn_cnt_reg <= 8'h0;
         btn_prev_reg <= 1'b1;
         gen_out_reg  <= mprg_pkg::GEN_OUT_RESET;
         gen_in_reg   <= mprg_pkg::GEN_IN_IDLE;
         out_reg      <= 6'h06; // carrier reset and disk/off low, others idle
      end else begin
         state_reg    <= state_next;
         target_reg   <= target_next;
         warn_cnt_reg <= warn_cnt_next;
         btn_prev_reg <= btn_prev_next;
         gen_out_reg  <= gen_out_next;
         gen_in_reg   <= gen_in_next;
         out_reg      <= out_next;
      end
   end

   // outputs; the ram indicator is left for the carrier to invert
   assign gen_out         = gen_out_reg;
   assign gen_in_value    = gen_in_reg;
   assign carrier_reset_n = out_reg[0];
   assign suspend_warn_n  = out_reg[1];
   assign sleep_ram_n     = out_reg[2];
   assign sleep_disk_n    = out_reg[3];
   assign soft_off_n      = out_reg[3];
   assign battery_event   = out_reg[4];
   assign over_temp       = out_reg[5];
   assign mgmt_irq        = ~syn[mprg_pkg::IX_ALERT] & ~alert_wake_en;

   // checks
   a_gen_out_low: assert property (@(posedge clock) disable iff (!rst_n)
      hw_reset |=> gen_out == 4'h0)
      else $error("general outputs not low after reset cause");
   a_gen_in_pull: assert property (@(posedge clock) disable iff (!rst_n)
      gen_in_driven == 4'h0 |=> gen_in_value == 4'hf)
      else $error("undriven inputs not read as one");
   a_btn_wake: assert property (@(posedge clock) disable iff (!rst_n)
      (state_reg == mprg_pkg::MPRG_OFF && btn_rise)
      |=> state_reg == mprg_pkg::MPRG_ON)
      else $error("power button edge did not leave soft-off");
   a_rst_hold: assert property (@(posedge clock) disable iff (!rst_n)
      !syn[mprg_pkg::IX_RST_BTN] |=> !carrier_reset_n)
      else $error("reset button did not hold reset");
   a_reset_cause: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(hw_reset) |=> !carrier_reset_n)
      else $error("reset cause did not reach carrier");
   a_pwr_good: assert property (@(posedge clock) disable iff (!rst_n)
      !syn[mprg_pkg::IX_PWR_GOOD] |=> !carrier_reset_n)
      else $error("power not good but carrier out of reset");
   a_warn_first: assert property (@(posedge clock) disable iff (!rst_n)
      (state_reg == mprg_pkg::MPRG_ON && sleep_req != 2'h0)
      |=> !suspend_warn_n && sleep_ram_n)
      else $error("sleep entered without warning");
   a_ram_ind: assert property (@(posedge clock) disable iff (!rst_n)
      state_reg == mprg_pkg::MPRG_RAM |-> !sleep_ram_n)
      else $error("ram indicator not low in ram sleep");
   a_disk_off: assert property (@(posedge clock) disable iff (!rst_n)
      (state_reg == mprg_pkg::MPRG_DISK
       || state_reg == mprg_pkg::MPRG_OFF) |-> !soft_off_n)
      else $error("disk/off indicator not low");
   a_pcie_wake: assert property (@(posedge clock) disable iff (!rst_n)
      (state_reg == mprg_pkg::MPRG_RAM && !syn[mprg_pkg::IX_WAKE])
      |=> state_reg == mprg_pkg::MPRG_ON)
      else $error("pcie wake ignored");
   a_batt_event: assert property (@(posedge clock) disable iff (!rst_n)
      !syn[mprg_pkg::IX_BATT] |=> battery_event)
      else $error("battery event lost");
   a_temp_event: assert property (@(posedge clock) disable iff (!rst_n)
      !syn[mprg_pkg::IX_TEMP] |=> over_temp)
      else $error("temperature event lost");
   c_power_on: cover property (@(posedge clock) disable iff (!rst_n)
      state_reg == mprg_pkg::MPRG_OFF ##1 state_reg == mprg_pkg::MPRG_ON);
   c_ram_sleep: cover property (@(posedge clock) disable iff (!rst_n)
      state_reg == mprg_pkg::MPRG_RAM);
   c_disk_wake: cover property (@(posedge clock) disable iff (!rst_n)
      state_reg == mprg_pkg::MPRG_DISK ##1 state_reg == mprg_pkg::MPRG_ON);
   c_alert_irq: cover property (@(posedge clock) disable iff (!rst_n)
      mgmt_irq);
endmodule

// ### hdl/mprg_pkg.sv
// constants and types of the module power, reset and pin control block
package mprg_pkg;
   localparam int          GEN_WIDTH       = 4;        // general pins
   localparam logic [3:0]  GEN_OUT_RESET   = 4'h0;     // outputs low
   localparam logic [3:0]  GEN_IN_IDLE     = 4'hf;     // pulled-high read
   localparam int          SYNC_STAGES     = 2;        // synchroniser depth
   localparam int          IN_COUNT        = 9;        // synchronised inputs
   // positions of synchronised inputs
   localparam int          IX_PWR_BTN      = 0;
   localparam int          IX_RST_BTN      = 1;
   localparam int          IX_PWR_GOOD     = 2;
   localparam int          IX_WAKE         = 3;
   localparam int          IX_BATT         = 4;
   localparam int          IX_TEMP         = 5;
   localparam int          IX_ALERT        = 6;
   localparam int          IX_SUPPLY       = 7;
   localparam int          IX_WDOG         = 8;
   localparam logic [8:0]  SYNC_RESET      = 9'h1ff;   // idle levels
   // suspend warning lead before a sleep state is entered
   localparam int          WARN_TIME_NS    = 1000;
   localparam int          CLOCK_NS        = 10;
   localparam int          WARN_CYCLES     = (WARN_TIME_NS + CLOCK_NS - 1)
                                             / CLOCK_NS;
   localparam logic [7:0]  WARN_COUNT      = 8'(WARN_CYCLES);
   // requested sleep depth from software
   localparam logic [1:0]  REQ_NONE        = 2'h0;
   localparam logic [1:0]  REQ_RAM         = 2'h1;
   localparam logic [1:0]  REQ_DISK        = 2'h2;
   localparam logic [1:0]  REQ_OFF         = 2'h3;

   typedef enum logic [2:0] {
      MPRG_OFF, MPRG_ON, MPRG_WARN, MPRG_RAM, MPRG_DISK
   } mprg_state_type;
endpackage

// ### hdl/mprg_sync.sv
// two-stage synchroniser bank for asynchronous inputs
`timescale 1ns/1ps
module mprg_sync #(
   parameter int             WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input  wire logic             clock,    // system clock
   input  wire logic             rst_n,    // synchronised reset
   input  wire logic [WIDTH-1:0] async_in, // raw inputs
   output logic      [WIDTH-1:0] sync_out  // stable copies
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   // second stage reads first stage only
   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   // register both stages
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= INIT;
         sync_reg <= INIT;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule

// ### dv/mprg_carrier.sv
// carrier board model: buttons, supply, sensors and general inputs
`timescale 1ns/1ps
module mprg_carrier (
   input  wire logic       clock,            // standby clock
   input  wire logic       sleep_ram_n,      // ram-sleep indicator
   output logic            power_button_n,   // power button
   output logic            reset_button_n,   // reset button
   output logic            main_power_good,  // supply good
   output logic            pcie_wake_n,      // pcie wake
   output logic            battery_low_n,    // battery low
   output logic            over_temp_n,      // temp sensor
   output logic            mgmt_alert_n,     // management alert
   output logic      [3:0] gen_in,           // general inputs
   output logic      [3:0] gen_in_driven,    // bits the carrier drives
   output logic            supply_switch_on  // main supply enable
);
   logic [3:0] gen_val;   // values on driven bits
   logic [3:0] float_pat = 4'h5; // undriven bits never hold steady
   // idle levels at time zero
   initial begin
      {power_button_n, reset_button_n, main_power_good, pcie_wake_n,
       battery_low_n, over_temp_n, mgmt_alert_n} = 7'h7f;
      gen_val = 4'h0;
      gen_in_driven = 4'h0;
   end
   // undriven pattern flips every cycle
   always @(negedge clock) begin
      float_pat <= ~float_pat;
   end
   assign gen_in = (gen_val & gen_in_driven) | (float_pat & ~gen_in_driven);
   assign supply_switch_on = ~sleep_ram_n;
   // pin levels: button, reset, good, wake, battery, temp, alert
   task automatic set_pins(input logic [6:0] lvl);
      {power_button_n, reset_button_n, main_power_good, pcie_wake_n,
       battery_low_n, over_temp_n, mgmt_alert_n} = lvl;
   endtask
   // values and drive mask of the general inputs
   task automatic set_gen(input logic [3:0] v, input logic [3:0] m);
      gen_val = v;
      gen_in_driven = m;
   endtask
endmodule

// ### dv/module_power_reset_gpio_control_tb_top.sv
// self-checking bench of the power, reset and general pin block
`timescale 1ns/1ps
module module_power_reset_gpio_control_tb_top;
   logic       clock;
   logic       reset_n;
   logic       main_supply_low;
   logic       watchdog_expired;
   logic       soft_reset_req;
   logic       alert_wake_en;
   logic [1:0] sleep_req;
   logic       gen_out_we;
   logic [3:0] gen_out_wdata;
   logic       power_button_n, reset_button_n, main_power_good;
   logic       pcie_wake_n, battery_low_n, over_temp_n, mgmt_alert_n;
   logic [3:0] gen_in, gen_in_driven, gen_out, gen_in_value;
   logic       carrier_reset_n, suspend_warn_n, sleep_ram_n;
   logic       sleep_disk_n, soft_off_n, battery_event, over_temp;
   logic       mgmt_irq, supply_switch_on;
   int         fails = 0;
   int         checks_done = 0;
   // design under test
   mprg_top mprg_top_inst (.clock(clock), .reset_n(reset_n),
      .power_button_n(power_button_n), .reset_button_n(reset_button_n),
      .main_power_good(main_power_good), .main_supply_low(main_supply_low),
      .watchdog_expired(watchdog_expired), .soft_reset_req(soft_reset_req),
      .pcie_wake_n(pcie_wake_n), .battery_low_n(battery_low_n),
      .over_temp_n(over_temp_n), .mgmt_alert_n(mgmt_alert_n),
      .alert_wake_en(alert_wake_en), .sleep_req(sleep_req),
      .gen_out_we(gen_out_we), .gen_out_wdata(gen_out_wdata),
      .gen_in(gen_in), .gen_in_driven(gen_in_driven), .gen_out(gen_out),
      .gen_in_value(gen_in_value), .carrier_reset_n(carrier_reset_n),
      .suspend_warn_n(suspend_warn_n), .sleep_ram_n(sleep_ram_n),
      .sleep_disk_n(sleep_disk_n), .soft_off_n(soft_off_n),
      .battery_event(battery_event), .over_temp(over_temp),
      .mgmt_irq(mgmt_irq));
   // carrier side
   mprg_carrier mprg_carrier_inst (.clock(clock), .sleep_ram_n(sleep_ram_n),
      .power_button_n(power_button_n), .reset_button_n(reset_button_n),
      .main_power_good(main_power_good), .pcie_wake_n(pcie_wake_n),
      .battery_low_n(battery_low_n), .over_temp_n(over_temp_n),
      .mgmt_alert_n(mgmt_alert_n), .gen_in(gen_in),
      .gen_in_driven(gen_in_driven), .supply_switch_on(supply_switch_on));
   // 100 MHz clock
   initial clock = 1'b0;
   always #5 clock = ~clock;
   // counts and verdict, ends the run
   task automatic close_out();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // compare one value with its expectation
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // n rising edges, then settle at the falling edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic pins(input logic [6:0] lvl);
      mprg_carrier_inst.set_pins(lvl);
   endtask
   // values held during reset
   task automatic t_reset();
      chk(gen_out, 4'h0);
      chk(gen_in_value, 4'hf);
      chk(carrier_reset_n, 1'b0);
      chk(sleep_disk_n, 1'b0);
      chk(soft_off_n, 1'b0);
      chk(sleep_ram_n, 1'b1);
      chk(suspend_warn_n, 1'b1);
      chk(battery_event, 1'b0);
      chk(over_temp, 1'b0);
      chk(mgmt_irq, 1'b0);
   endtask
   // power button press and release leaves soft-off
   task automatic t_power_on();
      pins(7'h3f);
      tick(4);
      chk(carrier_reset_n, 1'b0);
      pins(7'h7f);
      tick(1);
      chk(carrier_reset_n, 1'b0);
      tick(3);
      chk(carrier_reset_n, 1'b1);
      chk(sleep_disk_n, 1'b1);
   endtask
   // general outputs written, general inputs partly undriven
   task automatic t_gen();
      gen_out_wdata = 4'ha;
      gen_out_we = 1'b1;
      tick(1);
      gen_out_we = 1'b0;
      chk(gen_out, 4'ha);
      mprg_carrier_inst.set_gen(4'h6, 4'he);
      tick(3);
      chk(gen_in_value, 4'h7);
      mprg_carrier_inst.set_gen(4'h0, 4'hf);
      tick(3);
      chk(gen_in_value, 4'h0);
   endtask
   // each reset cause in turn pulls the carrier reset
   task automatic t_causes();
      for (int i = 0; i < 5; i++) begin
         if (i == 0) pins(7'h5f);
         if (i == 1) pins(7'h6f);
         main_supply_low = (i == 2);
         watchdog_expired = (i == 3);
         soft_reset_req = (i == 4);
         tick(4);
         chk(carrier_reset_n, 1'b0);
         chk(gen_out, 4'h0);
         pins(7'h7f);
         {main_supply_low, watchdog_expired, soft_reset_req} = 3'h0;
         tick(4);
         chk(carrier_reset_n, 1'b1);
      end
   endtask
   // battery, temperature and alert events
   task automatic t_events();
      alert_wake_en = 1'b0;
      pins(7'h7b);
      tick(2);
      chk(battery_event, 1'b0);
      tick(1);
      chk(battery_event, 1'b1);
      pins(7'h7d);
      tick(4);
      chk(battery_event, 1'b0);
      chk(over_temp, 1'b1);
      pins(7'h7e);
      tick(4);
      chk(mgmt_irq, 1'b1);
      pins(7'h7f);
      tick(4);
      chk(mgmt_irq, 1'b0);
      chk(over_temp, 1'b0);
   endtask
   // sleep request, warning lead, sleep levels, then a wake attempt
   task automatic t_sleep(input logic [1:0] req, input logic ram,
                          input logic disk, input logic [6:0] wake,
                          input logic woke);
      sleep_req = req;
      tick(0);
      sleep_req = mprg_pkg::REQ_NONE;
      tick(0);
      chk(suspend_warn_n, 1'b0);
      tick(mprg_pkg::WARN_CYCLES / 2);
      chk(sleep_ram_n, 1'b1);
      chk(sleep_disk_n, 1'b1);
      tick(mprg_pkg::WARN_CYCLES);
      chk(sleep_ram_n, ram);
      chk(sleep_disk_n, disk);
      chk(soft_off_n, disk);
      chk(supply_switch_on, !ram);
      pins(wake);
      tick(2);
      pins(7'h7f);
      tick(5);
      chk(sleep_ram_n, 1'b1);
      chk(sleep_disk_n, woke);
      chk(suspend_warn_n, 1'b1);
   endtask
   // stimulus sequence
   initial begin
      reset_n = 1'b0;
      {main_supply_low, watchdog_expired, soft_reset_req} = 3'h0;
      {alert_wake_en, gen_out_we, gen_out_wdata} = 6'h00;
      sleep_req = mprg_pkg::REQ_NONE;
      tick(12);
      t_reset();
      reset_n = 1'b1;
      tick(3);
      t_power_on();
      t_gen();
      t_causes();
      t_events();
      t_sleep(mprg_pkg::REQ_RAM, 1'b0, 1'b1, 7'h77, 1'b1);
      alert_wake_en = 1'b1;
      t_sleep(mprg_pkg::REQ_DISK, 1'b1, 1'b0, 7'h7e, 1'b1);
      t_sleep(mprg_pkg::REQ_OFF, 1'b1, 1'b0, 7'h77, 1'b0);
      t_power_on();
      close_out();
   end
   // hang guard
   initial begin
      repeat (5000) @(posedge clock);
      fails++;
      close_out();
   end
endmodule
